// ### design/pswin_pkg.sv
// Shared constants, types and register map for the program space data window
package pswin_pkg;

  // Widths of the data side and the program memory side
  localparam int unsigned DATA_ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned PM_WORD_W = 24;
  localparam int unsigned PAGE_W = 8;
  localparam int unsigned OFFS_W = 15;
  localparam int unsigned PM_ADDR_W = PAGE_W + OFFS_W;
  localparam int unsigned APB_ADDR_W = 12;
  localparam int unsigned APB_DATA_W = 32;

  // Window region: top data address bit selects it
  localparam int unsigned WINDOW_SEL_BIT = 15;
  localparam logic [DATA_ADDR_W-1:0] WINDOW_BASE = 16'h8000;

  // Register byte offsets
  localparam logic [APB_ADDR_W-1:0] CORE_CTRL_OFFSET = 12'h000;
  localparam logic [APB_ADDR_W-1:0] PAGE_OFFSET = 12'h004;
  localparam logic [APB_ADDR_W-1:0] STATUS_OFFSET = 12'h008;

  // Field positions and reset values
  localparam int unsigned WINDOW_ENABLE_BIT = 2;
  localparam int unsigned STATUS_BUSY_BIT = 0;
  localparam int unsigned STATUS_STALL_BIT = 1;
  localparam int unsigned STATUS_LAST_WIN_BIT = 2;
  localparam int unsigned STATUS_W = 3;
  localparam logic WINDOW_ENABLE_RESET = 1'b0;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 8'h00;

  // Extra stall cycles added to a windowed read
  localparam int unsigned EXTRA_W = 2;
  localparam logic [EXTRA_W-1:0] EXTRA_NONE = 2'h0;
  localparam logic [EXTRA_W-1:0] EXTRA_ONE = 2'h1;
  localparam logic [EXTRA_W-1:0] EXTRA_TWO = 2'h2;

  // Class of the instruction that issues the read
  typedef enum logic [1:0] {
    CLASS_WORD_MOVE,
    CLASS_DWORD_MOVE,
    CLASS_OTHER
  } instr_class_t;

  // Core data read request
  typedef struct packed {
    logic [DATA_ADDR_W-1:0] addr;
    instr_class_t cls;
    logic in_repeat;
    logic rep_first;
    logic rep_last;
    logic rep_irq_exit;
    logic rep_irq_reenter;
  } rd_req_t;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_ADDR_W-1:0] paddr;
    logic [APB_DATA_W-1:0] pwdata;
  } apb_req_t;

  // APB answer from this slave
  typedef struct packed {
    logic [APB_DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

endpackage : pswin_pkg

// ### design/window_regs.sv
// APB register file: core control, window page and status
`timescale 1ns/100ps
module window_regs (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire pswin_pkg::apb_req_t i_apb,
  output pswin_pkg::apb_rsp_t o_apb,
  input wire logic [pswin_pkg::STATUS_W-1:0] i_status,
  output logic o_window_enable,
  output logic [pswin_pkg::PAGE_W-1:0] o_page
);
  import pswin_pkg::*;

  // Phase and address decode
  wire setup = i_apb.psel && !i_apb.penable;
  wire access = i_apb.psel && i_apb.penable && o_apb.pready;
  wire hit_ctrl = i_apb.paddr == CORE_CTRL_OFFSET;
  wire hit_page = i_apb.paddr == PAGE_OFFSET;
  wire hit_status = i_apb.paddr == STATUS_OFFSET;
  wire mapped = hit_ctrl || hit_page || hit_status;
  wire [APB_DATA_W-1:0] ctrl_word = APB_DATA_W'({o_window_enable, 2'h0});
  wire [APB_DATA_W-1:0] page_word = APB_DATA_W'(o_page);
  wire [APB_DATA_W-1:0] status_word = APB_DATA_W'(i_status);
  wire [APB_DATA_W-1:0] rd_mux = hit_ctrl ? ctrl_word :
                                 hit_page ? page_word :
                                 hit_status ? status_word : 32'h0000_0000;

  // No wait state: answer prepared in setup, ready in the first access cycle
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_apb <= '0;
    end else begin
      o_apb.pready <= setup;
      o_apb.pslverr <= setup && !mapped;
      o_apb.prdata <= (setup && !i_apb.pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Writes land only at the completing edge
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_window_enable <= WINDOW_ENABLE_RESET;
      o_page <= PAGE_RESET;
    end else if (access && i_apb.pwrite) begin
      if (hit_ctrl) o_window_enable <= i_apb.pwdata[WINDOW_ENABLE_BIT];
      if (hit_page) o_page <= i_apb.pwdata[PAGE_W-1:0];
    end
  end

endmodule : window_regs

// ### design/window_stall_timer.sv
// Extra cycle choice and stall counter for windowed reads
`timescale 1ns/100ps
module window_stall_timer (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire pswin_pkg::rd_req_t i_req,
  input wire logic i_start,
  input wire logic [pswin_pkg::EXTRA_W-1:0] i_load,
  output logic [pswin_pkg::EXTRA_W-1:0] o_extra,
  output logic o_last
);
  import pswin_pkg::*;

  // Repeat edges that still pay the full penalty
  wire rep_edge = i_req.rep_first || i_req.rep_last || i_req.rep_irq_exit || i_req.rep_irq_reenter;
  wire is_move = (i_req.cls == CLASS_WORD_MOVE) || (i_req.cls == CLASS_DWORD_MOVE);
  logic [EXTRA_W-1:0] count;

  // Penalty selection by loop position and instruction class
  always_comb begin
    if (i_req.in_repeat) begin
      o_extra = rep_edge ? EXTRA_TWO : EXTRA_NONE;
    end else begin
      o_extra = is_move ? EXTRA_ONE : EXTRA_TWO;
    end
  end

  assign o_last = count == EXTRA_ONE;

  // Down counter of remaining stall cycles
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      count <= EXTRA_NONE;
    end else if (i_start) begin
      count <= i_load;
    end else if (count != EXTRA_NONE) begin
      count <= count - EXTRA_ONE;
    end
  end

endmodule : window_stall_timer

// ### design/program_space_data_window.sv
// Data space window onto a page of program memory, with APB registers
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
module program_space_data_window (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire pswin_pkg::apb_req_t i_apb,
  output pswin_pkg::apb_rsp_t o_apb,
  input wire logic i_rd_valid,
  input wire pswin_pkg::rd_req_t i_rd,
  input wire logic i_table_active,
  output logic o_busy,
  output logic o_stall,
  output logic o_rd_ack,
  output logic [pswin_pkg::DATA_W-1:0] o_rd_data,
  output logic o_pm_req,
  output logic [pswin_pkg::PM_ADDR_W-1:0] o_pm_addr,
  input wire logic [pswin_pkg::PM_WORD_W-1:0] i_pm_data,
  output logic o_dm_req,
  output logic [pswin_pkg::DATA_ADDR_W-1:0] o_dm_addr,
  input wire logic [pswin_pkg::DATA_W-1:0] i_dm_data
);
  import pswin_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DM_WAIT,
    ST_PM_WAIT,
    ST_CAPTURE,
    ST_STALL,
    ST_DONE
  } state_t;

  state_t state;
  state_t next_state;
  logic window_enable;
  logic [PAGE_W-1:0] page;
  logic [EXTRA_W-1:0] extra;
  logic [EXTRA_W-1:0] extra_q;
  logic stall_last;
  logic last_windowed;
  logic [STATUS_W-1:0] status;

  // Software side registers
  window_regs u_regs (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_apb(i_apb),
    .o_apb(o_apb),
    .i_status(status),
    .o_window_enable(window_enable),
    .o_page(page)
  );

  // Request decode: window hit needs top bit, enable and no table access
  wire accept = i_rd_valid && (state == ST_IDLE);
  wire top_bit = i_rd.addr[WINDOW_SEL_BIT];
  wire window_hit = top_bit && window_enable && !i_table_active;
  wire [PM_ADDR_W-1:0] pm_addr_map = {page, i_rd.addr[OFFS_W-1:0]};
  wire second_fetch = (state == ST_PM_WAIT) && (extra_q != EXTRA_NONE);
  wire timer_start = (state == ST_CAPTURE) && (extra_q != EXTRA_NONE);
  wire [DATA_W-1:0] read_word = last_windowed ? i_pm_data[DATA_W-1:0] : i_dm_data;
  wire loop_edge = i_rd.rep_first || i_rd.rep_last || i_rd.rep_irq_exit || i_rd.rep_irq_reenter;
  wire move_class = (i_rd.cls == CLASS_WORD_MOVE) || (i_rd.cls == CLASS_DWORD_MOVE);
  assign status = {last_windowed, o_stall, o_busy};

  // Penalty choice and stall count
  window_stall_timer u_timer (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_req(i_rd),
    .i_start(timer_start),
    .i_load(extra_q),
    .o_extra(extra),
    .o_last(stall_last)
  );

  // Next state of the read sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (accept) next_state = window_hit ? ST_PM_WAIT : ST_DM_WAIT;
      end
      ST_DM_WAIT: begin
        next_state = ST_CAPTURE;
      end
      ST_PM_WAIT: begin
        next_state = ST_CAPTURE;
      end
      ST_CAPTURE: begin
        next_state = (extra_q == EXTRA_NONE) ? ST_DONE : ST_STALL;
      end
      ST_STALL: begin
        if (stall_last) next_state = ST_DONE;
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Request capture and penalty latch
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      extra_q <= EXTRA_NONE;
      last_windowed <= 1'b0;
    end else if (accept) begin
      extra_q <= window_hit ? extra : EXTRA_NONE;
      last_windowed <= window_hit;
    end
  end

  // Program memory port: second fetch when the access is penalised
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_pm_req <= 1'b0;
      o_pm_addr <= '0;
    end else begin
      o_pm_req <= (accept && window_hit) || second_fetch;
      if (accept && window_hit) o_pm_addr <= pm_addr_map;
    end
  end

  // Data memory port for ordinary reads
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_dm_req <= 1'b0;
      o_dm_addr <= '0;
    end else begin
      o_dm_req <= accept && !window_hit;
      if (accept && !window_hit) o_dm_addr <= i_rd.addr;
    end
  end

  // Answer, stall and busy outputs; memory data taken one cycle after the fetch
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_rd_ack <= 1'b0;
      o_rd_data <= '0;
      o_stall <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_rd_ack <= (next_state == ST_DONE);
      if (state == ST_CAPTURE) begin
        o_rd_data <= read_word;
      end
      o_stall <= (next_state == ST_STALL);
      o_busy <= (next_state != ST_IDLE);
    end
  end

  // Checks on routing, address forming and timing
  sequence s_win_fetch;
    o_pm_req && !o_dm_req;
  endsequence

  sequence s_answer;
    o_rd_ack && !o_stall;
  endsequence

  property p_window_route;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      accept && top_bit && window_enable && !i_table_active |=> s_win_fetch;
  endproperty
  a_window_route: assert property (p_window_route) else $error("windowed read not sent to program memory");

  property p_below_base;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      accept && (i_rd.addr < WINDOW_BASE) |=> o_dm_req && !o_pm_req;
  endproperty
  a_below_base: assert property (p_below_base) else $error("read below window base reached program memory");

  property p_page_bits;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      accept && window_hit |=> o_pm_addr[PM_ADDR_W-1:OFFS_W] == $past(page);
  endproperty
  a_page_bits: assert property (p_page_bits) else $error("program address page bits wrong");

  property p_offset_bits;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      accept && window_hit |=> o_pm_addr[OFFS_W-1:0] == $past(i_rd.addr[OFFS_W-1:0]);
  endproperty
  a_offset_bits: assert property (p_offset_bits) else $error("program address offset bits shifted");

  property p_low_half;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      accept && window_hit && (extra == EXTRA_NONE) |-> ##3 s_answer ##0 (o_rd_data == $past(i_pm_data[DATA_W-1:0]));
  endproperty
  a_low_half: assert property (p_low_half) else $error("windowed data is not the low program half");

  property p_two_fetches;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      accept && window_hit && (extra != EXTRA_NONE) |=> o_pm_req [*2];
  endproperty
  a_two_fetches: assert property (p_two_fetches) else $error("penalised windowed read lacks second fetch");

  property p_table_suspend;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      accept && i_table_active |=> !o_pm_req;
  endproperty
  a_table_suspend: assert property (p_table_suspend) else $error("window used during table access");

  property p_one_extra;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      accept && window_hit && (extra == EXTRA_ONE) |-> ##3 o_stall ##1 s_answer;
  endproperty
  a_one_extra: assert property (p_one_extra) else $error("move through window not one extra cycle");

  property p_two_extra;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      accept && window_hit && (extra == EXTRA_TWO) |-> ##3 (o_stall && !o_rd_ack) [*2] ##1 s_answer;
  endproperty
  a_two_extra: assert property (p_two_extra) else $error("windowed read not two extra cycles");

  property p_plain_read;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      accept && !window_hit |=> !o_stall [*2] ##1 s_answer;
  endproperty
  a_plain_read: assert property (p_plain_read) else $error("plain data read stalled");

  // Penalty shapes: one or two stall cycles, then the answer
  sequence s_one_stall;
    (o_stall && !o_rd_ack) ##1 s_answer;
  endsequence

  sequence s_two_stall;
    (o_stall && !o_rd_ack) [*2] ##1 s_answer;
  endsequence

  property p_move_cost;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      accept && window_hit && !i_rd.in_repeat && move_class |-> ##3 s_one_stall;
  endproperty
  a_move_cost: assert property (p_move_cost) else $error("windowed move outside loop not one extra cycle");

  property p_other_cost;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      accept && window_hit && !i_rd.in_repeat && !move_class |-> ##3 s_two_stall;
  endproperty
  a_other_cost: assert property (p_other_cost) else $error("windowed other instruction not two extra cycles");

  property p_loop_edge_cost;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      accept && window_hit && i_rd.in_repeat && loop_edge |-> ##3 s_two_stall;
  endproperty
  a_loop_edge_cost: assert property (p_loop_edge_cost) else $error("loop edge read not two extra cycles");

  property p_loop_mid_cost;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      accept && window_hit && i_rd.in_repeat && !loop_edge |-> ##3 s_answer;
  endproperty
  a_loop_mid_cost: assert property (p_loop_mid_cost) else $error("mid loop windowed read stalled");

  property p_plain_data;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      accept && !window_hit |-> ##3 s_answer ##0 (o_rd_data == $past(i_dm_data));
  endproperty
  a_plain_data: assert property (p_plain_data) else $error("plain read data not from data memory");

  property p_plain_addr;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      accept && !window_hit |=> o_dm_addr == $past(i_rd.addr);
  endproperty
  a_plain_addr: assert property (p_plain_addr) else $error("plain read address altered");

  property p_disabled;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      accept && !window_enable |=> !o_pm_req ##1 !o_pm_req;
  endproperty
  a_disabled: assert property (p_disabled) else $error("program memory used with window disabled");

  property p_ack_pulse;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      o_rd_ack |=> !o_rd_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("read answer longer than one cycle");

  property p_busy_hold;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      accept |=> o_busy [*3];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped during a read");

  property p_page_write;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      i_apb.psel && i_apb.penable && o_apb.pready && i_apb.pwrite && (i_apb.paddr == PAGE_OFFSET)
        |=> page == $past(i_apb.pwdata[PAGE_W-1:0]);
  endproperty
  a_page_write: assert property (p_page_write) else $error("page register write lost");

endmodule : program_space_data_window

// ### tb/prog_data_mem_model.sv
// Program and data memory model on the far side of the window
`timescale 1ns/100ps
module prog_data_mem_model (
  input wire logic i_clk_sys,
  input wire logic i_pm_req,
  input wire logic [pswin_pkg::PM_ADDR_W-1:0] i_pm_addr,
  output logic [pswin_pkg::PM_WORD_W-1:0] o_pm_data,
  input wire logic i_dm_req,
  input wire logic [pswin_pkg::DATA_ADDR_W-1:0] i_dm_addr,
  output logic [pswin_pkg::DATA_W-1:0] o_dm_data
);
  import pswin_pkg::*;

  // Stored constant: upper byte filled with ones so it decodes as no-op
  function automatic logic [PM_WORD_W-1:0] pm_word(input logic [PM_ADDR_W-1:0] a);
    return {8'hff, a[15:0] ^ {a[22:15], 8'h3c}};
  endfunction : pm_word

  initial begin
    o_pm_data = '0;
    o_dm_data = '0;
  end

  // One-cycle read latency; outside a read the lines toggle, never hold stale data
  always @(posedge i_clk_sys) begin
    o_pm_data <= i_pm_req ? pm_word(i_pm_addr) : ~o_pm_data;
    o_dm_data <= i_dm_req ? (i_dm_addr ^ 16'ha5c3) : ~o_dm_data;
  end
endmodule : prog_data_mem_model

// ### tb/program_space_data_window_bench.sv
// Self-checking bench for the program space data window
`timescale 1ns/100ps
module program_space_data_window_bench;
  import pswin_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  apb_req_t i_apb = '0;
  apb_rsp_t o_apb;
  logic i_rd_valid = 1'b0;
  rd_req_t i_rd = '0;
  logic i_table_active = 1'b0;
  logic o_busy, o_stall, o_rd_ack, o_pm_req, o_dm_req;
  logic [DATA_W-1:0] o_rd_data, i_dm_data;
  logic [PM_ADDR_W-1:0] o_pm_addr;
  logic [PM_WORD_W-1:0] i_pm_data;
  logic [DATA_ADDR_W-1:0] o_dm_addr;
  logic [31:0] seed = 32'he299;
  logic en = 1'b0;
  logic [7:0] page = 8'h00;
  logic last_hit = 1'b0;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;

  program_space_data_window i_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_apb(i_apb), .o_apb(o_apb),
    .i_rd_valid(i_rd_valid), .i_rd(i_rd), .i_table_active(i_table_active), .o_busy(o_busy),
    .o_stall(o_stall), .o_rd_ack(o_rd_ack), .o_rd_data(o_rd_data), .o_pm_req(o_pm_req),
    .o_pm_addr(o_pm_addr), .i_pm_data(i_pm_data), .o_dm_req(o_dm_req), .o_dm_addr(o_dm_addr),
    .i_dm_data(i_dm_data));

  prog_data_mem_model i_mem (.i_clk_sys(i_clk_sys), .i_pm_req(o_pm_req), .i_pm_addr(o_pm_addr),
    .o_pm_data(i_pm_data), .i_dm_req(o_dm_req), .i_dm_addr(o_dm_addr), .o_dm_data(i_dm_data));

  // Clock and hang guard
  initial begin
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      test_done();
    end
  end

  // Xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Expected penalty cycles of a windowed read
  function automatic int extra(input rd_req_t q);
    if (!q.in_repeat) return (q.cls == CLASS_OTHER) ? 2 : 1;
    return (q.rep_first | q.rep_last | q.rep_irq_exit | q.rep_irq_reenter) ? 2 : 0;
  endfunction : extra

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer: setup, access until pready, then release
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge i_clk_sys);
    i_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge i_clk_sys);
    i_apb.penable <= 1'b1;
    do @(posedge i_clk_sys); while (o_apb.pready !== 1'b1);
    r = o_apb.prdata;
    e = o_apb.pslverr;
    i_apb <= '0;
  endtask : apb

  // One core read; dbl keeps the request up for one more cycle while busy, which must be ignored
  task automatic rd(input rd_req_t q, input logic tbl, input logic dbl);
    logic hit;
    logic [23:0] w;
    int e, cyc, nst, npm, ndm, nbz;
    hit = q.addr[15] & en & !tbl;
    e = hit ? extra(q) : 0;
    w = i_mem.pm_word({page, q.addr[14:0]});
    cyc = 0;
    nst = 0;
    npm = 0;
    ndm = 0;
    nbz = 0;
    @(posedge i_clk_sys);
    i_rd_valid <= 1'b1;
    i_rd <= q;
    i_table_active <= tbl;
    @(posedge i_clk_sys);
    i_rd_valid <= dbl;
    i_rd <= rd_req_t'(~q);
    i_table_active <= ~tbl;
    do begin
      @(posedge i_clk_sys);
      cyc++;
      nst += o_stall;
      nbz += o_busy;
      npm += o_pm_req;
      ndm += o_dm_req;
      i_rd_valid <= 1'b0;
    end while (o_rd_ack !== 1'b1 && cyc < 30);
    chk(cyc, 3 + e);
    chk(nbz, 3 + e);
    chk(nst, e);
    chk(o_rd_data, hit ? w[15:0] : (q.addr ^ 16'ha5c3));
    chk(ndm, {31'h0, !hit});
    chk(npm, hit ? ((e != 0) ? 2 : 1) : 0);
    if (hit) chk(o_pm_addr, {page, q.addr[14:0]});
    else chk(o_dm_addr, q.addr);
    last_hit = hit;
  endtask : rd

  task automatic test_done();
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  // Main sequence: reset values, refused offset, then mixed random reads
  initial begin
    logic [31:0] r, d;
    logic e;
    rd_req_t q;
    repeat (5) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    apb(1'b0, CORE_CTRL_OFFSET, 32'h0, r, e);
    chk(r, 32'h0);
    apb(1'b0, PAGE_OFFSET, 32'h0, r, e);
    chk(r, 32'h0);
    apb(1'b1, 12'h00c, 32'hffffffff, r, e);
    chk({r[30:0], e}, 32'h1);
    for (int i = 0; i < 80; i++) begin
      if (i % 8 == 0) begin
        d = rnd();
        d[2] = d[2] | (i == 0);
        en = d[2];
        apb(1'b1, CORE_CTRL_OFFSET, d, r, e);
        apb(1'b0, CORE_CTRL_OFFSET, 32'h0, r, e);
        chk(r, {29'h0, en, 2'h0});
        d = rnd();
        page = d[7:0];
        apb(1'b1, PAGE_OFFSET, d, r, e);
        apb(1'b0, PAGE_OFFSET, 32'h0, r, e);
        chk(r, {24'h0, page});
      end
      d = rnd();
      q = rd_req_t'(d[22:0]);
      q.cls = (d[31:30] == 2'h3) ? CLASS_OTHER : instr_class_t'(d[31:30]);
      if (i == 0) q.addr = 16'h8000;
      if (i == 1) q.addr = 16'hffff;
      if (i == 2) q.addr = 16'h7fff;
      if (i % 4 == 1) q[4:0] = 5'h10;
      rd(q, d[29:28] == 2'h0, d[27]);
    end
    apb(1'b0, STATUS_OFFSET, 32'h0, r, e);
    chk({r[2:0], e}, {last_hit, 3'h0});
    test_done();
  end
endmodule : program_space_data_window_bench
